// file: psp_pkg.sv
package psp_pkg;

    // ****************************************************************
    // Widths and field positions.
    // ****************************************************************
    localparam int DW           = 8;
    localparam int CW           = 3;
    localparam int IN_FULL_BIT  = 7;
    localparam int OUT_FULL_BIT = 6;
    localparam int OVF_BIT      = 5;
    localparam int MODE_BIT     = 4;
    localparam int IRQ_BIT      = 7;
    localparam int CS_BIT       = 2;
    localparam int WR_BIT       = 1;
    localparam int RD_BIT       = 0;

    // ****************************************************************
    // Values after reset.
    // ****************************************************************
    localparam logic [DW-1:0] DATA_DIR_RST = 8'hff;
    localparam logic [DW-1:0] LATCH_RST    = 8'h00;
    localparam logic [CW-1:0] CTL_DIR_RST  = 3'h7;
    localparam logic [CW-1:0] CTL_LAT_RST  = 3'h0;
    localparam logic [DW-1:0] FLAGS_RST    = 8'h00;
    localparam logic [DW-1:0] ENABLES_RST  = 8'h00;
    localparam logic [DW-1:0] PRIO_RST     = 8'h7f;
    localparam logic [DW-1:0] ANALOG_RST   = 8'h00;

    // ****************************************************************
    // Host strobe timing in clock cycles.
    // ****************************************************************
    localparam int              CNT_W      = 4;
    localparam logic [CNT_W-1:0] SETUP_CYC = 4'h1;
    localparam logic [CNT_W-1:0] STROBE_CYC = 4'h8;
    localparam logic [CNT_W-1:0] HOLD_CYC  = 4'h1;
    localparam logic [CNT_W-1:0] GAP_CYC   = 4'h4;

    // ****************************************************************
    // Register selects of the processor-side port.
    // ****************************************************************
    typedef enum logic [3:0] {
        REG_DATA_PINS,
        REG_DATA_LATCH,
        REG_DATA_DIR,
        REG_CTL_PINS,
        REG_CTL_LATCH,
        REG_CTL_DIR,
        REG_PSP_CTL,
        REG_FLAGS,
        REG_ENABLES,
        REG_PRIO,
        REG_ANALOG
    } reg_sel_e;

endpackage

// file: psp_if.sv
interface psp_if;

    // ****************************************************************
    // Strobes, data lines and the resolved bus level.
    // ****************************************************************
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] host_dout;
    logic       host_doe;
    logic [7:0] dev_dout;
    logic [7:0] dev_doe;
    logic [7:0] bus;

    // An undriven line floats high through the board pull-up.
    assign bus = (dev_doe & dev_dout) | (~dev_doe & (host_doe ? host_dout : 8'hff));

    modport device (
        input  cs_n, rd_n, wr_n, bus,
        output dev_dout, dev_doe
    );

    modport host (
        output cs_n, rd_n, wr_n, host_dout, host_doe,
        input  bus
    );

endinterface

// file: signal_sync.sv
module signal_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         resetn,
    // Asynchronous level in, synchronised level out.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s st_d;
    sync_s st_q;

    // The first stage feeds only the second, never any logic.
    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // Both stages clear on reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

endmodule

// file: psp_device.sv
// Function
// - Mode bit turns data port into slave port.
// - Master reads and writes port latch asynchronously.
// - Control pins become read, write, chip select.
// - Software makes strobe pins inputs first.
// - Software sets strobe pins to digital.
// - Write captured when select and write low.
// - Read served when select and read low.
// - Strobe inputs use TTL thresholds in mode.
// - Input full flag shows unread byte.
// - Output full until master reads byte.
// - Overflow on write over unread byte.
// - Mode bit read/write, clear means GPIO.
// - Low four control bits read zero.
// - Slave port only in internal-program mode.
module psp_device (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Pins toward the external master.
    psp_if.device                     pins,
    // Processor register port.
    input  wire psp_pkg::reg_sel_e    reg_sel,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // Device operating mode.
    input  wire logic                 mcu_mode,
    // Status toward the rest of the device.
    output logic                      ttl_select,
    output logic                      irq_flag,
    output logic                      irq_enable,
    output logic                      irq_priority
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [7:0] out_latch;
        logic [7:0] in_latch;
        logic [7:0] data_dir;
        logic [2:0] ctl_latch;
        logic [2:0] ctl_dir;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] prio;
        logic [7:0] analog;
        logic       in_full;
        logic       out_full;
        logic       in_ovf;
        logic       mode;
        logic       wr_seen;
        logic       rd_seen;
        logic [7:0] dout;
        logic [7:0] doe;
        logic [7:0] rdata;
        logic       ttl;
    } dev_s;

    dev_s        st_d;
    dev_s        st_q;
    logic [10:0] pin_raw;
    logic [10:0] pin_s;
    logic [7:0]  s_data;
    logic        s_cs_n;
    logic        s_rd_n;
    logic        s_wr_n;
    logic        active;
    logic        wr_now;
    logic        rd_now;
    logic        wr_start;
    logic        rd_start;
    logic        xfer_end;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    // Data and strobes share one synchroniser so they stay aligned.
    assign pin_raw = {pins.bus, pins.cs_n, pins.rd_n, pins.wr_n};

    signal_sync #(.W(11)) pin_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (pin_raw),
        .dout   (pin_s)
    );

    assign s_data = pin_s[10:3];
    assign s_cs_n = pin_s[2];
    assign s_rd_n = pin_s[1];
    assign s_wr_n = pin_s[0];

    // ****************************************************************
    // Strobe decode.
    // ****************************************************************
    // The port answers only in internal-program mode.
    assign active = st_q.mode & mcu_mode;
    // The strobes are taken as inputs; software keeps them so.
    assign wr_now = active & ~s_cs_n & ~s_wr_n;
    assign rd_now = active & ~s_cs_n & ~s_rd_n;
    // Only the first cycle of a low pair counts as a transfer.
    assign wr_start = wr_now & ~st_q.wr_seen;
    assign rd_start = rd_now & ~st_q.rd_seen;
    assign xfer_end = (~wr_now & st_q.wr_seen) | (~rd_now & st_q.rd_seen);

    // ****************************************************************
    // Next state.
    // ****************************************************************
    // Clears come first and sets last, so a set in the same cycle wins.
    always_comb begin
        st_d = st_q;
        st_d.wr_seen = wr_now;
        st_d.rd_seen = rd_now;

        // External read empties the output latch.
        if (rd_start) begin
            st_d.out_full = 1'b0;
        end

        // Processor writes.
        if (reg_wr) begin
            unique case (reg_sel)
                psp_pkg::REG_DATA_PINS,
                psp_pkg::REG_DATA_LATCH: begin
                    st_d.out_latch = reg_wdata;
                    if (active) begin
                        st_d.out_full = 1'b1;
                    end
                end
                psp_pkg::REG_DATA_DIR: st_d.data_dir = reg_wdata;
                psp_pkg::REG_CTL_PINS,
                psp_pkg::REG_CTL_LATCH: st_d.ctl_latch = reg_wdata[2:0];
                psp_pkg::REG_CTL_DIR: st_d.ctl_dir = reg_wdata[2:0];
                psp_pkg::REG_PSP_CTL: begin
                    st_d.in_ovf = reg_wdata[psp_pkg::OVF_BIT];
                    st_d.mode = reg_wdata[psp_pkg::MODE_BIT];
                end
                psp_pkg::REG_FLAGS: st_d.flags = reg_wdata;
                psp_pkg::REG_ENABLES: st_d.enables = reg_wdata;
                psp_pkg::REG_PRIO: st_d.prio = reg_wdata;
                psp_pkg::REG_ANALOG: st_d.analog = reg_wdata;
                default: ;
            endcase
        end

        // Processor read of the port takes the waiting byte.
        if (reg_rd && reg_sel == psp_pkg::REG_DATA_PINS && active) begin
            st_d.in_full = 1'b0;
        end

        // External write lands in the input latch.
        if (wr_start) begin
            st_d.in_latch = s_data;
            if (st_d.in_full) begin
                st_d.in_ovf = 1'b1;
            end
            st_d.in_full = 1'b1;
        end

        // Every finished transfer raises the peripheral flag.
        if (xfer_end) begin
            st_d.flags[psp_pkg::IRQ_BIT] = 1'b1;
        end

        // Pin drive in slave mode: whole byte during a read, none otherwise; in general I/O, per direction bit.
        st_d.dout = st_d.out_latch;
        if (active) begin
            st_d.doe = {8{rd_now}};
        end else begin
            st_d.doe = ~st_d.data_dir;
        end

        // Threshold select follows the live mode.
        st_d.ttl = active;

        // Read data is latched on the strobe and held after it.
        if (reg_rd) begin
            unique case (reg_sel)
                psp_pkg::REG_DATA_PINS:
                    st_d.rdata = active ? st_q.in_latch : s_data;
                psp_pkg::REG_DATA_LATCH: st_d.rdata = st_q.out_latch;
                psp_pkg::REG_DATA_DIR: st_d.rdata = st_q.data_dir;
                psp_pkg::REG_CTL_PINS: st_d.rdata = {5'h00, s_cs_n, s_wr_n, s_rd_n};
                psp_pkg::REG_CTL_LATCH: st_d.rdata = {5'h00, st_q.ctl_latch};
                psp_pkg::REG_CTL_DIR: st_d.rdata = {5'h00, st_q.ctl_dir};
                psp_pkg::REG_PSP_CTL:
                    st_d.rdata = {st_q.in_full, st_q.out_full, st_q.in_ovf, st_q.mode,
                                  4'h0};
                psp_pkg::REG_FLAGS: st_d.rdata = st_q.flags;
                psp_pkg::REG_ENABLES: st_d.rdata = st_q.enables;
                psp_pkg::REG_PRIO: st_d.rdata = st_q.prio;
                psp_pkg::REG_ANALOG: st_d.rdata = st_q.analog;
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    // Reset leaves the port in general I/O with all pins as inputs.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q           <= '0;
            st_q.out_latch <= psp_pkg::LATCH_RST;
            st_q.in_latch  <= psp_pkg::LATCH_RST;
            st_q.data_dir  <= psp_pkg::DATA_DIR_RST;
            st_q.ctl_latch <= psp_pkg::CTL_LAT_RST;
            st_q.ctl_dir   <= psp_pkg::CTL_DIR_RST;
            st_q.flags     <= psp_pkg::FLAGS_RST;
            st_q.enables   <= psp_pkg::ENABLES_RST;
            st_q.prio      <= psp_pkg::PRIO_RST;
            st_q.analog    <= psp_pkg::ANALOG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // All outputs come from the state register.
    assign pins.dev_dout = st_q.dout;
    assign pins.dev_doe  = st_q.doe;
    assign reg_rdata     = st_q.rdata;
    assign ttl_select    = st_q.ttl;
    assign irq_flag      = st_q.flags[psp_pkg::IRQ_BIT];
    assign irq_enable    = st_q.enables[psp_pkg::IRQ_BIT];
    assign irq_priority  = st_q.prio[psp_pkg::IRQ_BIT];

endmodule

// file: psp_host.sv
module psp_host (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       resetn,
    // Pins toward the slave port.
    psp_if.host             pins,
    // User request.
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic [7:0] req_data,
    output logic            req_ready,
    // User answer.
    output logic            rsp_valid,
    output logic [7:0]      rsp_data
);

    typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD, GAP} host_state_e;

    typedef struct packed {
        host_state_e       state;
        logic [3:0]        cnt;
        logic              write;
        logic              cs_n;
        logic              rd_n;
        logic              wr_n;
        logic [7:0]        dout;
        logic              doe;
        logic              ready;
        logic              rsp_valid;
        logic [7:0]        rsp_data;
    } host_s;

    host_s      st_d;
    host_s      st_q;
    logic [7:0] s_bus;

    // Read data crosses in from the pins.
    signal_sync #(.W(8)) bus_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (pins.bus),
        .dout   (s_bus)
    );

    // ****************************************************************
    // Transfer sequencer.
    // ****************************************************************
    // The strobe is long enough to cover the slave's synchroniser.
    always_comb begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        unique case (st_q.state)
            IDLE: begin
                if (req_valid) begin
                    st_d.write = req_write;
                    st_d.dout  = req_data;
                    st_d.doe   = req_write;
                    st_d.cs_n  = 1'b0;
                    st_d.ready = 1'b0;
                    st_d.cnt   = psp_pkg::SETUP_CYC - 4'h1;
                    st_d.state = SETUP;
                end
            end
            SETUP: begin
                if (st_q.cnt == 4'h0) begin
                    st_d.wr_n  = ~st_q.write;
                    st_d.rd_n  = st_q.write;
                    st_d.cnt   = psp_pkg::STROBE_CYC - 4'h1;
                    st_d.state = STROBE;
                end else begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end
            end
            STROBE: begin
                if (st_q.cnt == 4'h0) begin
                    st_d.wr_n      = 1'b1;
                    st_d.rd_n      = 1'b1;
                    st_d.rsp_valid = 1'b1;
                    if (!st_q.write) begin
                        st_d.rsp_data = s_bus;
                    end
                    st_d.cnt   = psp_pkg::HOLD_CYC - 4'h1;
                    st_d.state = HOLD;
                end else begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end
            end
            HOLD: begin
                if (st_q.cnt == 4'h0) begin
                    st_d.cs_n  = 1'b1;
                    st_d.doe   = 1'b0;
                    st_d.cnt   = psp_pkg::GAP_CYC - 4'h1;
                    st_d.state = GAP;
                end else begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end
            end
            GAP: begin
                if (st_q.cnt == 4'h0) begin
                    st_d.ready = 1'b1;
                    st_d.state = IDLE;
                end else begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end
            end
        endcase
    end

    // Strobes idle high after reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= '0;
            st_q.state <= IDLE;
            st_q.cs_n  <= 1'b1;
            st_q.rd_n  <= 1'b1;
            st_q.wr_n  <= 1'b1;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign pins.cs_n      = st_q.cs_n;
    assign pins.rd_n      = st_q.rd_n;
    assign pins.wr_n      = st_q.wr_n;
    assign pins.host_dout = st_q.dout;
    assign pins.host_doe  = st_q.doe;
    assign req_ready      = st_q.ready;
    assign rsp_valid      = st_q.rsp_valid;
    assign rsp_data       = st_q.rsp_data;

endmodule

// file: psp_link_props.sv
module psp_link_props (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       resetn,
    // Link signals.
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [7:0] host_dout,
    input wire logic       host_doe,
    input wire logic [7:0] dev_dout,
    input wire logic [7:0] dev_doe,
    input wire logic [7:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Link checks.
    // ****************************************************************
    // All checks share one clock, and reset holds them off.
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_strobe_in_select: assert property ((!wr_n || !rd_n) |-> !cs_n)
        else $error("strobe seen without chip select");
    a_one_strobe: assert property (!(!wr_n && !rd_n))
        else $error("read and write strobes low together");
    a_write_hold: assert property ($fell(wr_n) |-> (!wr_n && !cs_n)[*8] ##1 wr_n)
        else $error("write strobe length wrong");
    a_read_hold: assert property ($fell(rd_n) |-> (!rd_n && !cs_n)[*8] ##1 rd_n)
        else $error("read strobe length wrong");
    a_host_write_data: assert property (!wr_n |-> host_doe && bus == host_dout)
        else $error("host data missing during write");
    a_host_quiet_read: assert property (!rd_n |-> !host_doe)
        else $error("host drives during read");
    a_no_bus_fight: assert property (!(host_doe && dev_doe != 8'h00))
        else $error("both ends drive the data lines");
    a_read_drive: assert property ($fell(rd_n) |-> ##[1:4] (dev_doe == 8'hff))
        else $error("device did not drive on read");
    a_drive_tail: assert property ($rose(rd_n) |-> ##[1:4] (dev_doe == 8'h00))
        else $error("device still drives after read");
    a_strobe_gap: assert property ($rose(cs_n) |-> cs_n[*3])
        else $error("chip select gap too short");

    // Main transfer kinds seen at the pins.
    c_write: cover property ($fell(wr_n));
    c_read: cover property ($fell(rd_n));
    c_drive: cover property (dev_doe == 8'hff && !rd_n && bus == dev_dout);
endmodule

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals and instances.
    // ****************************************************************
    logic                clk;
    logic                resetn;
    psp_pkg::reg_sel_e   reg_sel;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic                mcu_mode;
    logic                ttl_select;
    logic                irq_flag;
    logic                irq_enable;
    logic                irq_priority;
    logic                req_valid;
    logic                req_write;
    logic [7:0]          req_data;
    logic                req_ready;
    logic                rsp_valid;
    logic [7:0]          rsp_data;
    logic [7:0]          rd_v;
    int                  errors;
    int                  comparisons;
    int                  cycles;
    psp_pkg::reg_sel_e   sels [7];
    logic [7:0]          rst_v [7];

    psp_if link ();

    psp_device u_psp_device (.clk(clk), .resetn(resetn), .pins(link), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mcu_mode(mcu_mode), .ttl_select(ttl_select), .irq_flag(irq_flag),
        .irq_enable(irq_enable), .irq_priority(irq_priority));

    psp_host u_psp_host (.clk(clk), .resetn(resetn), .pins(link), .req_valid(req_valid),
        .req_write(req_write), .req_data(req_data), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));

    psp_link_props u_psp_link_props (.clk(clk), .resetn(resetn), .cs_n(link.cs_n),
        .rd_n(link.rd_n), .wr_n(link.wr_n), .host_dout(link.host_dout),
        .host_doe(link.host_doe), .dev_dout(link.dev_dout), .dev_doe(link.dev_doe),
        .bus(link.bus));

    // The clock toggles every 25 ns, for a period of 50 ns.
    always #25 clk = ~clk;

    // A hung handshake ends the run here rather than stalling forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    // Every comparison is counted; a mismatch is reported at once.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // A register write is a one-cycle pulse taken on the next edge.
    task automatic reg_write(input psp_pkg::reg_sel_e sel, input logic [7:0] d);
        @(posedge clk);
        #2 reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #2 reg_wr = 1'b0;
    endtask

    // Read data is registered, so it is settled just after the taking edge.
    task automatic reg_check(input psp_pkg::reg_sel_e sel, input logic [7:0] exp);
        @(posedge clk);
        #2 reg_sel = sel;
        reg_rd = 1'b1;
        @(posedge clk);
        #2 reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask

    // One host transfer; the trailing wait covers the device flag latency.
    task automatic host_xfer(input logic wr, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #2 n++;
        end
        @(posedge clk);
        #2 req_valid = 1'b1;
        req_write = wr;
        req_data = d;
        @(posedge clk);
        #2 req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 50) begin
            @(posedge clk);
            #2 n++;
        end
        if (rsp_valid !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: host transfer never answered", $time);
        end
        q = rsp_data;
        repeat (6) @(posedge clk);
        #2;
    endtask

    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        reg_sel = psp_pkg::REG_PSP_CTL;
        {reg_wr, reg_rd, reg_wdata, req_valid, req_write, req_data} = '0;
        mcu_mode = 1'b1;
        {errors, comparisons, cycles} = '0;
        sels = '{psp_pkg::REG_PSP_CTL, psp_pkg::REG_DATA_DIR, psp_pkg::REG_CTL_DIR,
            psp_pkg::REG_FLAGS, psp_pkg::REG_ENABLES, psp_pkg::REG_PRIO, psp_pkg::REG_ANALOG};
        rst_v = '{8'h00, 8'hff, 8'h07, 8'h00, 8'h00, 8'h7f, 8'h00};
        repeat (16) @(posedge clk);
        #2 resetn = 1'b1;
        for (int i = 0; i < 7; i++) reg_check(sels[i], rst_v[i]);
        reg_check(psp_pkg::reg_sel_e'(4'hf), 8'h00);
        check({6'h00, irq_enable, irq_priority}, 8'h00);
        $display("test reset values done");
        reg_write(psp_pkg::REG_CTL_DIR, 8'h07);
        reg_write(psp_pkg::REG_ANALOG, 8'h07);
        reg_write(psp_pkg::REG_PSP_CTL, 8'hdf);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h10);
        check({7'h00, ttl_select}, 8'h01);
        reg_check(psp_pkg::REG_CTL_PINS, 8'h07);
        $display("test mode select done");
        host_xfer(1'b1, 8'ha5, rd_v);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h90);
        check({7'h00, irq_flag}, 8'h01);
        reg_check(psp_pkg::REG_DATA_PINS, 8'ha5);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h10);
        reg_write(psp_pkg::REG_FLAGS, 8'h00);
        reg_check(psp_pkg::REG_FLAGS, 8'h00);
        $display("test host write done");
        host_xfer(1'b1, 8'h3c, rd_v);
        host_xfer(1'b1, 8'hc3, rd_v);
        reg_check(psp_pkg::REG_PSP_CTL, 8'hb0);
        reg_check(psp_pkg::REG_DATA_PINS, 8'hc3);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h30);
        reg_write(psp_pkg::REG_PSP_CTL, 8'h10);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h10);
        $display("test overflow done");
        for (int i = 0; i < 2; i++) begin
            reg_write((i == 0) ? psp_pkg::REG_DATA_PINS : psp_pkg::REG_DATA_LATCH,
                (i == 0) ? 8'h96 : 8'h69);
            reg_check(psp_pkg::REG_PSP_CTL, 8'h50);
            reg_write(psp_pkg::REG_FLAGS, 8'h00);
            host_xfer(1'b0, 8'h00, rd_v);
            check(rd_v, (i == 0) ? 8'h96 : 8'h69);
            reg_check(psp_pkg::REG_PSP_CTL, 8'h10);
            check({7'h00, irq_flag}, 8'h01);
        end
        $display("test host read done");
        reg_write(psp_pkg::REG_ENABLES, 8'h80);
        reg_write(psp_pkg::REG_PRIO, 8'h80);
        reg_check(psp_pkg::REG_PRIO, 8'h80);
        check({6'h00, irq_enable, irq_priority}, 8'h03);
        $display("test interrupt bits done");
        @(posedge clk);
        #2 mcu_mode = 1'b0;
        repeat (3) @(posedge clk);
        #2 check({7'h00, ttl_select}, 8'h00);
        host_xfer(1'b1, 8'h11, rd_v);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h10);
        mcu_mode = 1'b1;
        $display("test external bus mode done");
        reg_write(psp_pkg::REG_PSP_CTL, 8'h00);
        host_xfer(1'b1, 8'h3c, rd_v);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h00);
        check({7'h00, ttl_select}, 8'h00);
        reg_write(psp_pkg::REG_DATA_LATCH, 8'h5a);
        reg_check(psp_pkg::REG_PSP_CTL, 8'h00);
        reg_check(psp_pkg::REG_DATA_LATCH, 8'h5a);
        reg_write(psp_pkg::REG_DATA_DIR, 8'h00);
        repeat (4) @(posedge clk);
        #2 check(link.bus, 8'h5a);
        reg_check(psp_pkg::REG_DATA_PINS, 8'h5a);
        reg_write(psp_pkg::REG_DATA_DIR, 8'hff);
        $display("test general purpose mode done");
        end_sim();
    end
endmodule
